// >>> iepr_pkg.sv
// Constants and carrier types for the edge-to-pulse isolator channel.
// Assumes a single 100 MHz system clock shared by both halves.

package iepr_pkg;

	// ---------------------------------------------------------------
	// Clock rate
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 10000;  // 100 MHz

	// ---------------------------------------------------------------
	// Timing figures in their own units
	// ---------------------------------------------------------------
	localparam int PULSE_PS      = 2000;     // Barrier pulse, about 2 ns
	localparam int REFRESH_NS    = 2000;     // Idle time before refresh, 2 us
	localparam int WATCHDOG_NS   = 5000;     // Silence before timeout, 5 us

	// ---------------------------------------------------------------
	// Derived cycle counts
	// ---------------------------------------------------------------
	// Longest-time rounding, floored at one cycle; the pulse is one clock
	localparam int PULSE_CYC_RAW = PULSE_PS / CLK_PERIOD_PS;
	localparam int PULSE_CYC     = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
	// Least-time rounding up to whole cycles
	localparam int REFRESH_CYC   =
		(REFRESH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WATCHDOG_CYC  =
		(WATCHDOG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ---------------------------------------------------------------
	// Counter widths and compare points
	// ---------------------------------------------------------------
	localparam int IDLE_W        = 8;
	localparam int WD_W          = 9;
	localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(REFRESH_CYC - 1);
	localparam logic [WD_W-1:0]   WD_LAST   = WD_W'(WATCHDOG_CYC - 1);
	localparam logic [IDLE_W-1:0] IDLE_RST  = 8'h00;
	localparam logic [WD_W-1:0]   WD_RST    = 9'h000;

	// ---------------------------------------------------------------
	// Values after reset
	// ---------------------------------------------------------------
	localparam logic OUT_RST     = 1'b1;  // Output high until first pulse
	localparam logic TIMEOUT_RST = 1'b1;  // No pulse seen yet
	localparam logic LEVEL_RST   = 1'b0;

	// ---------------------------------------------------------------
	// Barrier pulse pair
	// ---------------------------------------------------------------
	typedef struct packed {
		logic pos;  // Set pulse: input high
		logic neg;  // Reset pulse: input low
	} iepr_pulse_s;

	localparam iepr_pulse_s PULSE_NONE = 2'h0;

endpackage : iepr_pkg

// >>> iepr_src_model.sv
// Logic source that drives the isolator channel's input side.
// Assumes the bench sets its requests at the rising edge of sys_clk.

`timescale 1ns/1ps
`default_nettype none

module iepr_src_model (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Requests from the bench
	input  wire logic req_level,
	input  wire logic req_power,
	// Pins toward the channel
	output var  logic data_in,
	output var  logic in_power_ok
);
	// -----------------------------------------------------------------
	// Registered drive
	// -----------------------------------------------------------------
	// A real source changes just after the clock, never mid-cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_in     <= 1'b0;
			in_power_ok <= 1'b1;
		end else begin
			data_in     <= req_level;
			in_power_ok <= req_power;
		end
	end
endmodule : iepr_src_model

`default_nettype wire

// >>> iepr_top.sv
// Edge-to-pulse isolator channel: encoder, barrier pulses and decoder.
// Assumes data_in and in_power_ok are synchronous to sys_clk.
//
// Function
// - Rising input edge sends a positive pulse, falling a negative one.
// - Decoder latches high on positive pulse, low on negative, holds between.
// - Input steady over 2 us sends repeated refresh pulses of current level.
// - No pulse for about 5 us forces output high via watchdog.

`timescale 1ns/1ps
`default_nettype none

module iepr_top (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	// Input side
	input  wire logic                 data_in,
	input  wire logic                 in_power_ok,
	// Barrier observation
	output iepr_pkg::iepr_pulse_s     barrier_pulse,
	// Output side
	output logic                      data_out,
	output logic                      wd_timeout
);

	// ---------------------------------------------------------------
	// Encoder state
	// ---------------------------------------------------------------
	logic                             level_reg;
	logic                             level_next;
	logic [iepr_pkg::IDLE_W-1:0]      idle_cnt_reg;
	logic [iepr_pkg::IDLE_W-1:0]      idle_cnt_next;
	iepr_pkg::iepr_pulse_s            pulse_reg;
	iepr_pkg::iepr_pulse_s            pulse_next;
	logic                             edge_seen;
	logic                             refresh_due;

	// Edge and refresh detection with next-value logic
	always_comb begin
		level_next    = data_in;
		pulse_next    = iepr_pkg::PULSE_NONE;
		edge_seen     = (data_in != level_reg);
		refresh_due   = (idle_cnt_reg == iepr_pkg::IDLE_LAST);
		idle_cnt_next = idle_cnt_reg;
		if (!in_power_ok) begin
			// Unpowered side is silent; refresh fires as soon as it returns
			idle_cnt_next = iepr_pkg::IDLE_LAST;
		end else if (edge_seen || refresh_due) begin
			pulse_next.pos = data_in;
			pulse_next.neg = !data_in;
			idle_cnt_next  = iepr_pkg::IDLE_RST;
		end else begin
			idle_cnt_next = idle_cnt_reg + 1'b1;
		end
	end

	// Encoder registers; pulses last exactly one clock
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_reg    <= iepr_pkg::LEVEL_RST;
			idle_cnt_reg <= iepr_pkg::IDLE_RST;
			pulse_reg    <= iepr_pkg::PULSE_NONE;
		end else begin
			level_reg    <= level_next;
			idle_cnt_reg <= idle_cnt_next;
			pulse_reg    <= pulse_next;
		end
	end

	assign barrier_pulse = pulse_reg;

	// ---------------------------------------------------------------
	// Decoder and watchdog state
	// ---------------------------------------------------------------
	logic                             out_reg;
	logic                             out_next;
	logic                             timeout_reg;
	logic                             timeout_next;
	logic [iepr_pkg::WD_W-1:0]        wd_cnt_reg;
	logic [iepr_pkg::WD_W-1:0]        wd_cnt_next;
	logic                             any_pulse;

	// Bistable latch with watchdog; a pulse always outranks the timeout
	always_comb begin
		any_pulse    = pulse_reg.pos || pulse_reg.neg;
		out_next     = out_reg;
		timeout_next = timeout_reg;
		wd_cnt_next  = wd_cnt_reg;
		if (any_pulse) begin
			out_next     = pulse_reg.pos;
			timeout_next = 1'b0;
			wd_cnt_next  = iepr_pkg::WD_RST;
		end else if (timeout_reg) begin
			// Hold high while silent; counter parked to save toggling
			out_next     = 1'b1;
		end else if (wd_cnt_reg == iepr_pkg::WD_LAST) begin
			out_next     = 1'b1;
			timeout_next = 1'b1;
		end else begin
			wd_cnt_next  = wd_cnt_reg + 1'b1;
		end
	end

	// Decoder registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_reg     <= iepr_pkg::OUT_RST;
			timeout_reg <= iepr_pkg::TIMEOUT_RST;
			wd_cnt_reg  <= iepr_pkg::WD_RST;
		end else begin
			out_reg     <= out_next;
			timeout_reg <= timeout_next;
			wd_cnt_reg  <= wd_cnt_next;
		end
	end

	assign data_out   = out_reg;
	assign wd_timeout = timeout_reg;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	localparam int REFRESH_GAP = iepr_pkg::REFRESH_CYC;

	// Helper: cycles since last encoder pulse while powered
	logic [iepr_pkg::IDLE_W:0]        gap_cnt_reg;
	logic [iepr_pkg::IDLE_W:0]        gap_cnt_next;
	logic                             gap_arm_reg;
	logic                             gap_arm_next;

	// Reset stands in for a pulse; the count lags the pulse by one edge
	always_comb begin
		gap_arm_next = 1'b1;
		gap_cnt_next = gap_cnt_reg;
		if (!gap_arm_reg || !in_power_ok
			|| pulse_reg.pos || pulse_reg.neg) begin
			gap_cnt_next = '0;
		end else if (gap_cnt_reg != '1) begin
			gap_cnt_next = gap_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_cnt_reg <= '0;
			gap_arm_reg <= 1'b0;
		end else begin
			gap_cnt_reg <= gap_cnt_next;
			gap_arm_reg <= gap_arm_next;
		end
	end

	property p_rise_pos;
		@(posedge sys_clk) disable iff (!rst_n)
		(in_power_ok && data_in && !level_reg)
			|=> (barrier_pulse.pos && !barrier_pulse.neg);
	endproperty
	a_rise_pos: assert property (p_rise_pos)
		else $error("rising edge gave no positive pulse");

	property p_fall_neg;
		@(posedge sys_clk) disable iff (!rst_n)
		(in_power_ok && !data_in && level_reg)
			|=> (barrier_pulse.neg && !barrier_pulse.pos);
	endproperty
	a_fall_neg: assert property (p_fall_neg)
		else $error("falling edge gave no negative pulse");

	// pulse is one clock wide
	// A toggle every cycle gives back-to-back pulses of opposite sign
	property p_pulse_narrow;
		@(posedge sys_clk) disable iff (!rst_n)
		(barrier_pulse.pos || barrier_pulse.neg)
			|=> (barrier_pulse != $past(barrier_pulse));
	endproperty
	a_pulse_narrow: assert property (p_pulse_narrow)
		else $error("barrier pulse wider than one clock");

	property p_latch_follow;
		@(posedge sys_clk) disable iff (!rst_n)
		(barrier_pulse.pos || barrier_pulse.neg)
			|=> (data_out == $past(barrier_pulse.pos));
	endproperty
	a_latch_follow: assert property (p_latch_follow)
		else $error("decoder did not follow pulse polarity");

	property p_latch_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		(!barrier_pulse.pos && !barrier_pulse.neg && !wd_timeout
			&& wd_cnt_reg != iepr_pkg::WD_LAST) |=> $stable(data_out);
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("decoder output changed without a pulse");

	property p_refresh_gap;
		@(posedge sys_clk) disable iff (!rst_n)
		gap_cnt_reg < REFRESH_GAP;
	endproperty
	a_refresh_gap: assert property (p_refresh_gap)
		else $error("steady input went without refresh");

	property p_refresh_level;
		@(posedge sys_clk) disable iff (!rst_n)
		(barrier_pulse.pos || barrier_pulse.neg)
			|-> (barrier_pulse.pos == level_reg);
	endproperty
	a_refresh_level: assert property (p_refresh_level)
		else $error("pulse polarity differs from input level");

	property p_wd_fire;
		@(posedge sys_clk) disable iff (!rst_n)
		(wd_cnt_reg == iepr_pkg::WD_LAST && !wd_timeout
			&& !barrier_pulse.pos && !barrier_pulse.neg)
			|=> (wd_timeout && data_out)
			##1 ((wd_timeout && data_out)
				|| $past(barrier_pulse.pos || barrier_pulse.neg));
	endproperty
	a_wd_fire: assert property (p_wd_fire)
		else $error("watchdog did not force output high");

	property p_wd_restart;
		@(posedge sys_clk) disable iff (!rst_n)
		(barrier_pulse.pos || barrier_pulse.neg)
			|=> (wd_cnt_reg == iepr_pkg::WD_RST && !wd_timeout);
	endproperty
	a_wd_restart: assert property (p_wd_restart)
		else $error("pulse did not restart watchdog");

	// Main scenarios
	property p_cov_edge;
		@(posedge sys_clk) disable iff (!rst_n)
		(in_power_ok && data_in != level_reg) ##1 barrier_pulse.pos;
	endproperty
	c_cov_edge: cover property (p_cov_edge);

	property p_cov_refresh;
		@(posedge sys_clk) disable iff (!rst_n)
		(in_power_ok && idle_cnt_reg == iepr_pkg::IDLE_LAST
			&& data_in == level_reg) ##1 barrier_pulse.neg;
	endproperty
	c_cov_refresh: cover property (p_cov_refresh);

	property p_cov_timeout;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(wd_timeout);
	endproperty
	c_cov_timeout: cover property (p_cov_timeout);

	property p_cov_recover;
		@(posedge sys_clk) disable iff (!rst_n)
		wd_timeout ##1 !wd_timeout ##1 !data_out;
	endproperty
	c_cov_recover: cover property (p_cov_recover);

endmodule : iepr_top

`default_nettype wire

// >>> iepr_top_tb.sv
// Self-checking bench for the edge-to-pulse isolator channel.
// Assumes iepr_pkg is compiled first and one 100 MHz clock.

`timescale 1ns/1ps
`default_nettype none

module iepr_top_tb;
	logic                  sys_clk;
	logic                  rst_n;
	logic                  req_level;
	logic                  req_power;
	logic                  data_in;
	logic                  in_power_ok;
	iepr_pkg::iepr_pulse_s barrier_pulse;
	logic                  data_out;
	logic                  wd_timeout;
	int                    mismatches;
	int                    check_count;
	int                    cycles;
	int                    gap;

	// -----------------------------------------------------------------
	// Clock, source and design
	// -----------------------------------------------------------------
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	iepr_src_model i_src (.sys_clk(sys_clk), .rst_n(rst_n),
		.req_level(req_level), .req_power(req_power),
		.data_in(data_in), .in_power_ok(in_power_ok));

	iepr_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .data_in(data_in),
		.in_power_ok(in_power_ok), .barrier_pulse(barrier_pulse),
		.data_out(data_out), .wd_timeout(wd_timeout));

	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	task automatic check(input string what, input logic [1:0] exp,
		input logic [1:0] seen);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Sample just after the edge so that its updates have landed
	task automatic step();
		@(posedge sys_clk);
		#1;
	endtask : step

	// Returns at the edge where the source pins take the new values
	task automatic set_in(input logic lvl, input logic pwr);
		@(posedge sys_clk);
		req_level <= lvl;
		req_power <= pwr;
		@(posedge sys_clk);
	endtask : set_in

	// Cycles until the next pulse, bounded so a silent encoder shows
	task automatic wait_pulse(output int n);
		n = 0;
		do begin
			step();
			n++;
		end while (barrier_pulse === iepr_pkg::PULSE_NONE && n < 1000);
	endtask : wait_pulse

	task automatic give_verdict();
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	// Single edges and two toggles on consecutive cycles
	task automatic test_edges();
		set_in(1'b1, 1'b1);
		step();
		check("pulse rise", 2'h2, barrier_pulse);
		step();
		check("pulse width", 2'h0, barrier_pulse);
		check("out set", 2'h1, {1'b0, data_out});
		check("wd clear", 2'h0, {1'b0, wd_timeout});
		set_in(1'b0, 1'b1);
		step();
		check("pulse fall", 2'h1, barrier_pulse);
		step();
		check("out reset", 2'h0, {1'b0, data_out});
		@(posedge sys_clk);
		req_level <= 1'b1;
		@(posedge sys_clk);
		req_level <= 1'b0;
		step();
		check("toggle rise", 2'h2, barrier_pulse);
		step();
		check("toggle fall", 2'h1, barrier_pulse);
		check("toggle out", 2'h1, {1'b0, data_out});
		step();
		check("toggle end", 2'h0, {1'b0, data_out});
	endtask : test_edges

	// Steady input at each level repeats pulses of that level
	task automatic test_refresh(input logic lvl);
		set_in(lvl, 1'b1);
		wait_pulse(gap);
		wait_pulse(gap);
		check("refresh gap", 2'h0,
			(gap == iepr_pkg::REFRESH_CYC) ? 2'h0 : 2'h3);
		check("refresh pol", {lvl, ~lvl}, barrier_pulse);
		wait_pulse(gap);
		check("refresh again", 2'h0,
			(gap == iepr_pkg::REFRESH_CYC) ? 2'h0 : 2'h3);
		check("out held", {1'b0, lvl}, {1'b0, data_out});
		check("wd alive", 2'h0, {1'b0, wd_timeout});
	endtask : test_refresh

	// Silent encoder trips the watchdog, power back resumes output
	task automatic test_watchdog();
		set_in(1'b0, 1'b1);
		wait_pulse(gap);
		@(posedge sys_clk);
		req_power <= 1'b0;
		#1;
		repeat (iepr_pkg::WATCHDOG_CYC - 1) step();
		check("wd early", 2'h0, {1'b0, wd_timeout});
		check("out early", 2'h0, {1'b0, data_out});
		step();
		check("wd expired", 2'h1, {1'b0, wd_timeout});
		check("out forced", 2'h1, {1'b0, data_out});
		check("silent", 2'h0, barrier_pulse);
		set_in(1'b0, 1'b1);
		step();
		check("power pulse", 2'h1, barrier_pulse);
		step();
		check("resume out", 2'h0, {1'b0, data_out});
		check("resume wd", 2'h0, {1'b0, wd_timeout});
	endtask : test_watchdog

	// -----------------------------------------------------------------
	// Hang guard
	// -----------------------------------------------------------------
	// Whole run needs about 1530 cycles; 5000 leaves over three times that as ceiling
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			give_verdict();
		end
	end

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		rst_n       = 1'b0;
		req_level   = 1'b0;
		req_power   = 1'b1;
		mismatches  = 0;
		check_count = 0;
		cycles      = 0;
		repeat (4) @(posedge sys_clk);
		#1;
		check("rst pulse", 2'h0, barrier_pulse);
		check("rst out", 2'h1, {1'b0, data_out});
		check("rst wd", 2'h1, {1'b0, wd_timeout});
		rst_n = 1'b1;
		test_edges();
		test_refresh(1'b0);
		test_refresh(1'b1);
		test_watchdog();
		give_verdict();
	end
endmodule : iepr_top_tb

`default_nettype wire
